// file: rtl/lpmcc_consts.vh
// constants for the low power mode clock control block
// Overview of operation
// - speed-up bit high runs slow crystal fast-start; low runs it low-power
// - speed-up bit frozen while slow crystal is the system clock source
// - setting crystal enable clears the stable flag; flag sets once stable
// - stable flag rises after 1024 crystal clocks from enable
// - crystal control bits 7..3 read zero; flag read-only; others r/w reset 0
// - crystal control bit 0 enables the slow crystal oscillator
// - writing 111 to clock select in full-speed mode enters slow mode
// - slow mode entry completes only once the selected slow oscillator is stable
// - writing 000..110 in slow mode returns to fast clock divided 1..64
// - halt with both keep-in-idle bits 0 enters sleep, core clock stops
// - halt with low keep 1, high keep 0 enters idle_sub_only: fast off, sub on
// - halt with both keep bits 1 enters idle_both_clocks: both clocks run
// - halt with high keep 1, low keep 0 enters idle_fast_only: fast on, sub off unless the watchdog is enabled
// - entering sleep or idle holds memory, registers and port states
// - entering sleep or idle sets power-down flag and clears time-out flag
// - entering sleep or idle clears watchdog; it runs on only if enabled
// - clock select 000..110 pick fast clock /1../64, 111 picks sub clock
// - low source select 0 picks slow rc, 1 picks slow crystal
`ifndef LPMCC_CONSTS_VH
`define LPMCC_CONSTS_VH
`define LPMCC_ADDR_SYS_CLK_CTRL 8'h00
`define LPMCC_ADDR_XTAL_CTRL 8'h01
`define LPMCC_ADDR_STATUS 8'h02
`define LPMCC_CKS_HI 7
`define LPMCC_CKS_LO 5
`define LPMCC_FHS_BIT 3
`define LPMCC_FSS_BIT 2
`define LPMCC_HKEEP_BIT 1
`define LPMCC_LKEEP_BIT 0
`define LPMCC_XSP_BIT 2
`define LPMCC_XEN_BIT 0
`define LPMCC_CKS_SUB 3'h7
`define LPMCC_SCC_RESET 8'h00
`define LPMCC_XTAL_STABLE_CLKS 1024
`define LPMCC_M_NORMAL 6'h01
`define LPMCC_M_SLOW 6'h02
`define LPMCC_M_SLEEP 6'h04
`define LPMCC_M_IDLE_SUB_ONLY 6'h08
`define LPMCC_M_IDLE_BOTH_CLOCKS 6'h10
`define LPMCC_M_IDLE_FAST_ONLY 6'h20
`endif

// file: rtl/lpmcc_clk_div.v
// glitch-free power-of-two divider working on a one-cycle enable
module lpmcc_clk_div #(
   parameter CNT_W = 6
) (
   input wire sysClk,
   input wire rst,
   input wire tickIn,
   input wire [2:0] ratioSel,
   input wire restart,
   output reg tickOut
);
   reg [CNT_W-1:0] cnt_q;
   reg [2:0] selEff_q;
   wire [CNT_W-1:0] lastCnt;
   wire wrap;

   assign lastCnt = (({{(CNT_W-1){1'b0}}, 1'b1}) << selEff_q) - {{(CNT_W-1){1'b0}}, 1'b1};
   assign wrap = tickIn && (cnt_q == lastCnt);

   // a new ratio takes effect at a wrap or on restart; only a restart cuts a period short
   always @(posedge sysClk or posedge rst) begin
      if (rst) begin
         cnt_q <= {CNT_W{1'b0}};
         selEff_q <= 3'h0;
         tickOut <= 1'b0;
      end else if (restart) begin
         cnt_q <= {CNT_W{1'b0}};
         selEff_q <= ratioSel;
         tickOut <= 1'b0;
      end else begin
         tickOut <= wrap;
         if (wrap) begin
            cnt_q <= {CNT_W{1'b0}};
            selEff_q <= ratioSel;
         end else if (tickIn) begin
            cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule

// file: rtl/lpmcc_top.v
// clock source and power mode control: registers, mode machine, clock enables
`include "lpmcc_consts.vh"
module lpmcc_top #(
   parameter XTAL_STABLE_CLKS = `LPMCC_XTAL_STABLE_CLKS
) (
   input wire sys_clk,
   input wire rst,
   input wire [7:0] regAddr,
   input wire [7:0] regWdata,
   input wire regWe,
   input wire regRe,
   output reg [7:0] regRdata,
   input wire haltExec,
   input wire wakeUp,
   input wire clrWdtExec,
   input wire wdtTimeout,
   input wire wdtEnable,
   input wire highOscEnReq,
   input wire fastOscStablePin,
   input wire xtalClkPin,
   input wire rcClkPin,
   output reg coreClkEn,
   output reg fastClkEn,
   output reg subClkEn,
   output reg cpuRun,
   output reg holdState,
   output reg highOscOn,
   output reg xtalOscOn,
   output reg rcOscOn,
   output reg xtalSpeedup,
   output reg wdtClear,
   output reg wdtRun,
   output reg powerDownFlag,
   output reg wdtTimeoutFlag
);
   localparam NORMAL = `LPMCC_M_NORMAL;
   localparam SLOW = `LPMCC_M_SLOW;
   localparam SLEEP = `LPMCC_M_SLEEP;
   localparam IDLE_SUB_ONLY = `LPMCC_M_IDLE_SUB_ONLY;
   localparam IDLE_BOTH_CLOCKS = `LPMCC_M_IDLE_BOTH_CLOCKS;
   localparam IDLE_FAST_ONLY = `LPMCC_M_IDLE_FAST_ONLY;
   localparam [7:0] SCC_RESET = `LPMCC_SCC_RESET;

   // register state
   reg [2:0] sysClockSelect_q;
   reg fastSrcSelect_q;
   reg lowFreqSourceSelect_q;
   reg highOscKeepInIdle_q;
   reg lowOscKeepInIdle_q;
   reg crystalSpeedup_q;
   reg slowCrystalEnable_q;
   reg slowCrystalStableFlag_q;
   reg [10:0] xtalCnt_q;
   reg [5:0] mode_q;
   reg [5:0] mode_d;
   reg slowPend_q;
   reg srcSub_q;
   reg fssEff_q;

   // pin synchronisers: stage one feeds stage two only
   reg [1:0] fastSync_q;
   reg [1:0] xtalSync_q;
   reg [1:0] rcSync_q;
   reg xtalLast_q;
   reg rcLast_q;

   wire fastStable;
   wire xtalTick;
   wire rcTick;
   wire subTick;
   wire subStable;
   wire fastTick;
   wire divTick;
   wire sclWr;
   wire xtcWr;
   wire halting;
   wire sleepLike;
   wire subOn;
   wire fastOn;
   wire xtalIsSys;
   wire [5:0] runMode;
   wire divRestart;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fastSync_q <= 2'h0;
         xtalSync_q <= 2'h0;
         rcSync_q <= 2'h0;
         xtalLast_q <= 1'b0;
         rcLast_q <= 1'b0;
      end else begin
         fastSync_q <= {fastSync_q[0], fastOscStablePin};
         xtalSync_q <= {xtalSync_q[0], xtalClkPin};
         rcSync_q <= {rcSync_q[0], rcClkPin};
         xtalLast_q <= xtalSync_q[1];
         rcLast_q <= rcSync_q[1];
      end
   end

   assign fastStable = fastSync_q[1];
   assign xtalTick = xtalSync_q[1] && !xtalLast_q && slowCrystalEnable_q;
   assign rcTick = rcSync_q[1] && !rcLast_q;
   assign subTick = fssEff_q ? xtalTick : rcTick;
   // slow rc is taken as ready as soon as it runs
   assign subStable = lowFreqSourceSelect_q ? slowCrystalStableFlag_q : 1'b1;
   assign fastTick = highOscOn && fastStable;

   assign sclWr = regWe && (regAddr == `LPMCC_ADDR_SYS_CLK_CTRL);
   assign xtcWr = regWe && (regAddr == `LPMCC_ADDR_XTAL_CTRL);
   assign halting = haltExec && cpuRun;
   assign sleepLike = (mode_q == SLEEP) || (mode_q == IDLE_SUB_ONLY) ||
      (mode_q == IDLE_BOTH_CLOCKS) || (mode_q == IDLE_FAST_ONLY);
   assign runMode = (sysClockSelect_q == `LPMCC_CKS_SUB) ? SLOW : NORMAL;
   assign xtalIsSys = (sysClockSelect_q == `LPMCC_CKS_SUB) && lowFreqSourceSelect_q;
   assign divRestart = !srcSub_q && !fastTick;

   // register writes
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sysClockSelect_q <= SCC_RESET[`LPMCC_CKS_HI:`LPMCC_CKS_LO];
         fastSrcSelect_q <= 1'b0;
         lowFreqSourceSelect_q <= 1'b0;
         highOscKeepInIdle_q <= 1'b0;
         lowOscKeepInIdle_q <= 1'b0;
         crystalSpeedup_q <= 1'b0;
         slowCrystalEnable_q <= 1'b0;
      end else begin
         if (sclWr) begin
            sysClockSelect_q <= regWdata[`LPMCC_CKS_HI:`LPMCC_CKS_LO];
            fastSrcSelect_q <= regWdata[`LPMCC_FHS_BIT];
            lowFreqSourceSelect_q <= regWdata[`LPMCC_FSS_BIT];
            highOscKeepInIdle_q <= regWdata[`LPMCC_HKEEP_BIT];
            lowOscKeepInIdle_q <= regWdata[`LPMCC_LKEEP_BIT];
         end
         if (xtcWr) begin
            slowCrystalEnable_q <= regWdata[`LPMCC_XEN_BIT];
            // changing drive strength under a running system clock is unsafe
            if (!xtalIsSys) begin
               crystalSpeedup_q <= regWdata[`LPMCC_XSP_BIT];
            end
         end
      end
   end

   // crystal stability counter: counts synchronised crystal edges
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         xtalCnt_q <= 11'h000;
         slowCrystalStableFlag_q <= 1'b0;
      end else if (!slowCrystalEnable_q || (xtcWr && regWdata[`LPMCC_XEN_BIT] &&
            !slowCrystalEnable_q)) begin
         xtalCnt_q <= 11'h000;
         slowCrystalStableFlag_q <= 1'b0;
      end else if (xtalTick && !slowCrystalStableFlag_q) begin
         xtalCnt_q <= xtalCnt_q + 11'h001;
         if (xtalCnt_q == XTAL_STABLE_CLKS[10:0] - 11'h001) begin
            slowCrystalStableFlag_q <= 1'b1;
         end
      end
   end

   // mode machine
   always @* begin
      mode_d = mode_q;
      case (mode_q)
         NORMAL: begin
            if (halting) begin
               case ({highOscKeepInIdle_q, lowOscKeepInIdle_q})
                  2'b00: mode_d = SLEEP;
                  2'b01: mode_d = IDLE_SUB_ONLY;
                  2'b11: mode_d = IDLE_BOTH_CLOCKS;
                  default: mode_d = IDLE_FAST_ONLY;
               endcase
            end else if (slowPend_q && subStable && srcSub_q) begin
               mode_d = SLOW;
            end
         end
         SLOW: begin
            if (halting) begin
               case ({highOscKeepInIdle_q, lowOscKeepInIdle_q})
                  2'b00: mode_d = SLEEP;
                  2'b01: mode_d = IDLE_SUB_ONLY;
                  2'b11: mode_d = IDLE_BOTH_CLOCKS;
                  default: mode_d = IDLE_FAST_ONLY;
               endcase
            end else if (sysClockSelect_q != `LPMCC_CKS_SUB) begin
               mode_d = NORMAL;
            end
         end
         SLEEP, IDLE_SUB_ONLY, IDLE_BOTH_CLOCKS, IDLE_FAST_ONLY: begin
            if (wakeUp) begin
               mode_d = runMode;
            end
         end
         default: mode_d = NORMAL;
      endcase
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mode_q <= NORMAL;
         slowPend_q <= 1'b0;
         srcSub_q <= 1'b0;
         fssEff_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         // slow entry waits for the chosen slow oscillator
         slowPend_q <= (sysClockSelect_q == `LPMCC_CKS_SUB) && (mode_q == NORMAL);
         // source swap lands on a sub clock edge so the first sub period is whole
         if (slowPend_q && subStable && subTick && !srcSub_q) begin
            srcSub_q <= 1'b1;
         end else if (mode_d == NORMAL) begin
            srcSub_q <= 1'b0;
         end
         if (!srcSub_q || subTick || !subStable) begin
            fssEff_q <= lowFreqSourceSelect_q;
         end
      end
   end

   lpmcc_clk_div u_div (
      .sysClk(sys_clk),
      .rst(rst),
      .tickIn(fastTick),
      .ratioSel(sysClockSelect_q == `LPMCC_CKS_SUB ? 3'h0 : sysClockSelect_q),
      .restart(divRestart),
      .tickOut(divTick)
   );

   // which oscillators run in each mode
   assign fastOn = (mode_q == NORMAL) || (mode_q == IDLE_BOTH_CLOCKS) || (mode_q == IDLE_FAST_ONLY) ||
      ((mode_q == SLOW) && highOscEnReq);
   // in sleep and idle_fast_only the sub clock lives on only for the watchdog
   assign subOn = (mode_q == NORMAL) || (mode_q == SLOW) || (mode_q == IDLE_SUB_ONLY) ||
      (mode_q == IDLE_BOTH_CLOCKS) || (((mode_q == SLEEP) || (mode_q == IDLE_FAST_ONLY)) && wdtEnable);

   // power-down and time-out flags; a timeout beats a same-cycle clear
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         powerDownFlag <= 1'b0;
         wdtTimeoutFlag <= 1'b0;
      end else begin
         if (halting) begin
            powerDownFlag <= 1'b1;
         end else if (clrWdtExec) begin
            powerDownFlag <= 1'b0;
         end
         if (wdtTimeout) begin
            wdtTimeoutFlag <= 1'b1;
         end else if (halting || clrWdtExec) begin
            wdtTimeoutFlag <= 1'b0;
         end
      end
   end

   // registered outputs
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         coreClkEn <= 1'b0;
         fastClkEn <= 1'b0;
         subClkEn <= 1'b0;
         cpuRun <= 1'b1;
         holdState <= 1'b0;
         highOscOn <= 1'b1;
         xtalOscOn <= 1'b0;
         rcOscOn <= 1'b1;
         xtalSpeedup <= 1'b0;
         wdtClear <= 1'b0;
         wdtRun <= 1'b0;
      end else begin
         cpuRun <= (mode_d == NORMAL) || (mode_d == SLOW);
         holdState <= !((mode_d == NORMAL) || (mode_d == SLOW));
         // the core gets no clock edge after the halt cycle
         coreClkEn <= !sleepLike && !halting &&
            (srcSub_q ? (subTick && subStable) : divTick);
         fastClkEn <= fastOn && fastTick;
         subClkEn <= subOn && subTick;
         highOscOn <= fastOn;
         xtalOscOn <= slowCrystalEnable_q;
         rcOscOn <= !lowFreqSourceSelect_q && subOn;
         xtalSpeedup <= crystalSpeedup_q;
         wdtClear <= halting;
         wdtRun <= wdtEnable;
      end
   end

   // read port: data in the cycle after the strobe
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         regRdata <= 8'h00;
      end else if (regRe) begin
         case (regAddr)
            `LPMCC_ADDR_SYS_CLK_CTRL: regRdata <= {sysClockSelect_q, 1'b0,
               fastSrcSelect_q, lowFreqSourceSelect_q, highOscKeepInIdle_q,
               lowOscKeepInIdle_q};
            `LPMCC_ADDR_XTAL_CTRL: regRdata <= {5'h00, crystalSpeedup_q,
               slowCrystalStableFlag_q, slowCrystalEnable_q};
            `LPMCC_ADDR_STATUS: regRdata <= {mode_q, wdtTimeoutFlag, powerDownFlag};
            default: regRdata <= 8'h00;
         endcase
      end else begin
         regRdata <= 8'h00;
      end
   end
endmodule

// file: tb/lpmcc_top_asserts.sv
// concurrent checks on the clock control top ports
module lpmcc_top_asserts #(
   parameter XTAL_STABLE_CLKS = 1024
) (
   input wire sys_clk,
   input wire rst,
   input wire [7:0] regAddr,
   input wire [7:0] regWdata,
   input wire regWe,
   input wire regRe,
   input wire [7:0] regRdata,
   input wire haltExec,
   input wire wakeUp,
   input wire clrWdtExec,
   input wire wdtTimeout,
   input wire wdtEnable,
   input wire cpuRun,
   input wire holdState,
   input wire coreClkEn,
   input wire highOscOn,
   input wire wdtClear,
   input wire wdtRun,
   input wire powerDownFlag,
   input wire wdtTimeoutFlag
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   reg hKeep_q;
   // shadow of the fast keep bit; the mode it picks is not visible on any pin
   always @(posedge sys_clk or posedge rst) begin
      if (rst) hKeep_q <= 1'b0;
      else if (regWe && regAddr == 8'h00) hKeep_q <= regWdata[1];
   end
   sequence haltTaken;
      haltExec && cpuRun;
   endsequence
   sequence parked;
      !cpuRun && holdState && !coreClkEn;
   endsequence
   a_halt_parks: assert property (haltTaken |=> parked)
      else $error("halt did not park the core");
   a_halt_flags: assert property (haltTaken and !wdtTimeout |=> powerDownFlag && !wdtTimeoutFlag)
      else $error("halt flags wrong");
   a_clear_once: assert property (haltTaken |=> wdtClear ##1 !wdtClear)
      else $error("watchdog clear not a single pulse");
   a_run_follows: assert property ($rose(holdState) |-> wdtRun == $past(wdtEnable))
      else $error("watchdog run does not follow enable");
   a_hold_still: assert property (holdState |-> !coreClkEn && !cpuRun)
      else $error("core clocked while held");
   a_wake_resume: assert property (holdState && wakeUp |=> cpuRun && !holdState)
      else $error("wake did not resume");
   a_fast_off: assert property ($rose(holdState) && !hKeep_q |-> ##[0:4] !highOscOn)
      else $error("fast oscillator left on");
   a_fast_kept: assert property ($rose(holdState) && hKeep_q |-> highOscOn [*4])
      else $error("fast oscillator dropped");
   a_pd_sticky: assert property (powerDownFlag && !clrWdtExec |=> powerDownFlag)
      else $error("power down flag lost");
   a_read_idle: assert property (!regRe |=> regRdata == 8'h00)
      else $error("read data without read");
   a_xtal_upper: assert property (regRe && regAddr == 8'h01 |=> regRdata[7:3] == 5'h00)
      else $error("crystal upper bits not zero");
endmodule
bind lpmcc_top lpmcc_top_asserts #(.XTAL_STABLE_CLKS(XTAL_STABLE_CLKS)) i_lpmcc_top_asserts (
   .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWe(regWe),
   .regRe(regRe), .regRdata(regRdata), .haltExec(haltExec), .wakeUp(wakeUp),
   .clrWdtExec(clrWdtExec), .wdtTimeout(wdtTimeout), .wdtEnable(wdtEnable), .cpuRun(cpuRun),
   .holdState(holdState), .coreClkEn(coreClkEn), .highOscOn(highOscOn), .wdtClear(wdtClear),
   .wdtRun(wdtRun), .powerDownFlag(powerDownFlag), .wdtTimeoutFlag(wdtTimeoutFlag));

// file: tb/lpmcc_tb_top.sv
// self-checking bench for the clock control top
`include "lpmcc_consts.vh"
module lpmcc_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] ASC = `LPMCC_ADDR_SYS_CLK_CTRL;
   localparam logic [7:0] AXT = `LPMCC_ADDR_XTAL_CTRL;
   localparam logic [7:0] AST = `LPMCC_ADDR_STATUS;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWdata = 8'h00;
   logic regWe = 1'b0;
   logic regRe = 1'b0;
   logic wdtEnable = 1'b0;
   logic fastStablePin = 1'b1;
   logic [3:0] evPulse = 4'h0;
   logic [2:0] slowDiv = 3'h0;
   wire [7:0] regRdata;
   wire coreClkEn, cpuRun, holdState, highOscOn, xtalOscOn, xtalSpeedup;
   wire wdtClear, wdtRun, powerDownFlag, wdtTimeoutFlag;
   wire fastClkEn, subClkEn, rcOscOn;
   int badCount = 0;
   int testsRun = 0;
   logic [7:0] modeExp [4] = '{8'h10, 8'h20, 8'h80, 8'h40};
   lpmcc_top #(.XTAL_STABLE_CLKS(8)) i_lpmcc_top (
      .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWe(regWe),
      .regRe(regRe), .regRdata(regRdata), .haltExec(evPulse[0]), .wakeUp(evPulse[1]),
      .clrWdtExec(evPulse[2]), .wdtTimeout(evPulse[3]), .wdtEnable(wdtEnable),
      .highOscEnReq(1'b0), .fastOscStablePin(fastStablePin), .xtalClkPin(slowDiv[2]),
      .rcClkPin(slowDiv[1]), .coreClkEn(coreClkEn), .fastClkEn(fastClkEn), .subClkEn(subClkEn),
      .cpuRun(cpuRun), .holdState(holdState), .highOscOn(highOscOn), .xtalOscOn(xtalOscOn),
      .rcOscOn(rcOscOn), .xtalSpeedup(xtalSpeedup), .wdtClear(wdtClear), .wdtRun(wdtRun),
      .powerDownFlag(powerDownFlag), .wdtTimeoutFlag(wdtTimeoutFlag));
   always #20 sys_clk = ~sys_clk;
   // slow oscillators run free, eight and four system cycles per period
   always @(posedge sys_clk) slowDiv <= slowDiv + 3'h1;
   task automatic wrapUp;
      $display("comparisons %0d mismatches %0d", testsRun, badCount);
      if (badCount == 0 && testsRun > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      testsRun++;
      if (got !== exp) begin
         badCount++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWdata <= d;
      regWe <= 1'b1;
      @(posedge sys_clk);
      regWe <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regRe <= 1'b1;
      @(posedge sys_clk);
      regRe <= 1'b0;
      @(negedge sys_clk);
      d = regRdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(d, exp);
   endtask
   task automatic pollrd(input logic [7:0] a, input logic [7:0] exp, input int n);
      logic [7:0] d;
      for (int i = 0; i < n; i++) begin
         rd(a, d);
         if (d === exp) break;
      end
      chk(d, exp);
   endtask
   // counts core, sub and fast clock enable pulses over w cycles
   task automatic tally(input int w, output int nc, output int ns, output int nf);
      nc = 0;
      ns = 0;
      nf = 0;
      repeat (w) begin
         @(negedge sys_clk);
         nc += int'(coreClkEn);
         ns += int'(subClkEn);
         nf += int'(fastClkEn);
      end
   endtask
   // 0 halt, 1 wake, 2 clear watchdog, 3 watchdog overflow
   task automatic pulse(input int b);
      @(posedge sys_clk);
      evPulse[b] <= 1'b1;
      @(posedge sys_clk);
      evPulse[b] <= 1'b0;
      @(negedge sys_clk);
   endtask
   initial begin
      #400000;
      badCount++;
      wrapUp();
   end
   initial begin
      int k;
      int n;
      int s;
      int f;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      rdchk(ASC, 8'h00);
      rdchk(AXT, 8'h00);
      chk({7'h00, rcOscOn}, 8'h01);
      wr(AST, 8'hFF);
      wr(8'h07, 8'h5A);
      rdchk(8'h07, 8'h00);
      pollrd(AST, 8'h04, 20);
      $display("test reset_values done");
      wr(AXT, 8'hFF);
      rdchk(AXT, 8'h05);
      chk({6'h00, xtalOscOn, xtalSpeedup}, 8'h03);
      repeat (40) @(posedge sys_clk);
      rdchk(AXT, 8'h05);
      pollrd(AXT, 8'h07, 30);
      $display("test crystal_start done");
      wr(ASC, 8'hE4);
      pollrd(AST, 8'h08, 40);
      chk({7'h00, rcOscOn}, 8'h00);
      // the fast oscillator stops while the core runs slow
      @(posedge sys_clk);
      fastStablePin <= 1'b0;
      wr(AXT, 8'h01);
      rdchk(AXT, 8'h07);
      wr(ASC, 8'h24);
      rdchk(AST, 8'h04);
      tally(16, n, s, f);
      chk(n[7:0], 8'h00);
      // software waits for the fast oscillator before relying on full speed
      @(posedge sys_clk);
      fastStablePin <= 1'b1;
      repeat (8) @(posedge sys_clk);
      tally(16, n, s, f);
      chk(n[7:0], 8'h08);
      wr(AXT, 8'h01);
      rdchk(AXT, 8'h03);
      chk({7'h00, xtalSpeedup}, 8'h00);
      $display("test slow_mode done");
      for (k = 0; k < 7; k++) begin
         wr(ASC, {k[2:0], 5'h04});
         repeat (130) @(posedge sys_clk);
         tally(128, n, s, f);
         chk(n[7:0], 8'(128 >> k));
      end
      $display("test divider done");
      for (k = 0; k < 4; k++) begin
         @(posedge sys_clk);
         wdtEnable <= k[0] ^ k[1];
         wr(ASC, {6'h01, k[1:0]});
         pulse(3);
         rdchk(AST, 8'h06);
         pulse(0);
         chk({cpuRun, holdState, powerDownFlag, wdtTimeoutFlag, wdtClear, wdtRun, 2'b00},
            {5'b01101, k[0] ^ k[1], 2'b00});
         rdchk(AST, modeExp[k] | 8'h01);
         chk({7'h00, highOscOn}, {7'h00, k[1]});
         // sub runs in idle_sub_only and idle_both_clocks, and in sleep or idle_fast_only only for the watchdog
         tally(16, n, s, f);
         chk(s[7:0], (k == 0) ? 8'h00 : 8'h02);
         chk(f[7:0], k[1] ? 8'h10 : 8'h00);
         pulse(1);
         chk({7'h00, cpuRun}, 8'h01);
         rdchk(ASC, {6'h01, k[1:0]});
         pulse(2);
         rdchk(AST, 8'h04);
      end
      $display("test halt_modes done");
      wrapUp();
   end
endmodule
